/* File: verilog/spm_protect.sv */
`timescale 1ns/1ps
// Functional notes
// - the periodic timer period is modulus times prescaler (1 or 512) times four clocks.
// - the protection control register takes only the first write after reset and is always readable.
// - the watchdog enable bit turns the watchdog off at 0 and on at 1.
// - the watchdog prescale bit divides the watchdog clock by 512 when 1 and not at all when 0.
// - the watchdog timeout ratio is 2^9..2^15 unprescaled and 2^18..2^24 prescaled by timing field.
// - the halt monitor enable bit disables the halt monitor at 0 and enables it at 1.
// - the bus monitor enable bit switches monitoring of outgoing bus cycles off at 0 and on at 1.
// - the bus monitor timeout field selects 64, 32, 16 or 8 system clocks.
// - a zero modulus stops the periodic timer; reaching zero raises an interrupt and reloads.
// - a newly written nonzero modulus takes effect only when the current count completes; zero stops the count at once.
// - software writes the service sequence within the timeout; the service register reads zero.
// - the periodic timer clock is divided by four before it drives the modulus counter.
module spm_protect
    import spm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // monitored system
    input wire logic halt_detected,
    input wire logic ext_cycle_active,
    // protection outputs
    output logic system_reset_request,
    output logic bus_error,
    output logic irq
);

    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    function automatic logic [15:0] wd_limit(input logic [1:0] timing_sel);
        wd_limit = 16'((SPM_WD_BASE << {timing_sel, 1'b0}) - 16'h0001);
    endfunction : wd_limit

    function automatic logic [6:0] bm_limit(input logic [1:0] timing_sel);
        bm_limit = 7'((SPM_BM_BASE >> timing_sel) - 7'h01);
    endfunction : bm_limit

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    spm_ctrl_t ctrl_r;
    spm_ptimer_t ptimer_r;
    logic ctrl_locked_r;
    logic svc_armed_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic [8:0] wd_pre_r;
    logic [15:0] wd_cnt_r;
    logic [8:0] pit_pre_r;
    logic [1:0] pit_div_r;
    logic [7:0] pit_cnt_r;
    logic [6:0] bm_cnt_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic rst_req_r;
    logic bus_err_r;
    logic irq_r;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire logic req = avs_read | avs_write;
    wire logic do_wr = avs_write & ~wait_r;
    wire logic do_rd_cap = avs_read & wait_r;
    wire logic sel_ctrl = avs_address == SPM_OFS_CTRL;
    wire logic sel_ptimer = avs_address == SPM_OFS_PTIMER;
    wire logic sel_svc = avs_address == SPM_OFS_SVC;
    wire logic sel_stat = avs_address == SPM_OFS_STAT;
    wire logic sel_mask = avs_address == SPM_OFS_MASK;
    wire logic wr_ctrl = do_wr & sel_ctrl & ~ctrl_locked_r;
    wire logic wr_ptimer = do_wr & sel_ptimer;
    wire logic wr_svc = do_wr & sel_svc;
    wire logic wr_stat = do_wr & sel_stat;
    wire logic wr_mask = do_wr & sel_mask;
    wire logic [7:0] svc_byte = avs_writedata[7:0];

    // the service register always reads zero, like any unmapped word
    wire logic [31:0] rd_word = sel_ctrl ? {16'h0000, ctrl_r} :
                                sel_ptimer ? {16'h0000, ptimer_r} :
                                sel_stat ? {29'h0000_0000, stat_r} :
                                sel_mask ? {29'h0000_0000, mask_r} :
                                32'h0000_0000;

    // ----------------------------------------------------------------
    // software watchdog
    // ----------------------------------------------------------------
    wire logic wd_on = ctrl_r.watchdog_enable_bit;
    wire logic svc_done = wr_svc & svc_armed_r & (svc_byte == SPM_SVC_KEY2);
    wire logic svc_arm_nxt = wr_svc ? (svc_byte == SPM_SVC_KEY1) : svc_armed_r;
    wire logic wd_pre_wrap = wd_pre_r == SPM_PRE_MAX;
    wire logic wd_tick = wd_on & (~ctrl_r.watchdog_prescale_bit | wd_pre_wrap);
    // counting prescaled ticks to the same limit multiplies the ratio by 512
    wire logic [15:0] wd_lim = wd_limit(ctrl_r.watchdog_timing_field);
    wire logic wd_fire = wd_tick & ~svc_done & (wd_cnt_r == wd_lim);
    wire logic [8:0] wd_pre_nxt = (wd_on & ~svc_done) ? 9'(wd_pre_r + 9'h001) : 9'h000;
    wire logic [15:0] wd_cnt_nxt = (~wd_on | svc_done | wd_fire) ? 16'h0000 :
                                   wd_tick ? 16'(wd_cnt_r + 16'h0001) : wd_cnt_r;

    // ----------------------------------------------------------------
    // halt monitor
    // ----------------------------------------------------------------
    wire logic halt_fire = ctrl_r.halt_monitor_enable & halt_detected;

    // ----------------------------------------------------------------
    // bus monitor
    // ----------------------------------------------------------------
    wire logic bm_watch = ctrl_r.bus_monitor_external_enable & ext_cycle_active;
    wire logic [6:0] bm_lim = bm_limit(ctrl_r.bus_monitor_timing_field);
    wire logic bm_fire = bm_watch & (bm_cnt_r == bm_lim);
    // a master that ignores the error and keeps the cycle open sees it again
    wire logic [6:0] bm_cnt_nxt = (~bm_watch | bm_fire) ? 7'h00 : 7'(bm_cnt_r + 7'h01);

    // ----------------------------------------------------------------
    // periodic interrupt timer
    // ----------------------------------------------------------------
    wire logic pit_run = ptimer_r.periodic_timer_modulus != 8'h00;
    wire logic pit_pre_tick = ~ptimer_r.prescale | (pit_pre_r == SPM_PRE_MAX);
    wire logic pit_tick = pit_run & pit_pre_tick & (pit_div_r == SPM_PIT_DIV_MAX);
    wire logic pit_last = pit_cnt_r <= 8'h01;
    wire logic pit_fire = pit_tick & pit_last & (pit_cnt_r != 8'h00);
    wire logic [8:0] pit_pre_nxt = pit_run ? 9'(pit_pre_r + 9'h001) : 9'h000;
    wire logic [1:0] pit_div_nxt = ~pit_run ? 2'h0 :
                                   pit_pre_tick ? 2'(pit_div_r + 2'h1) : pit_div_r;
    // a new nonzero modulus is only picked up at reload, never mid-count; zero clears the count at once
    wire logic [7:0] pit_cnt_nxt = ~pit_run ? 8'h00 :
                                   (pit_cnt_r == 8'h00) ? ptimer_r.periodic_timer_modulus :
                                   ~pit_tick ? pit_cnt_r :
                                   pit_last ? ptimer_r.periodic_timer_modulus :
                                   8'(pit_cnt_r - 8'h01);

    // ----------------------------------------------------------------
    // interrupt status, mask and request
    // ----------------------------------------------------------------
    wire logic [2:0] evt = {bm_fire, wd_fire, pit_fire};
    logic [2:0] stat_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < SPM_NEVT; gi++) begin : g_stat
            // set beats a same-cycle write-one-to-clear
            assign stat_nxt[gi] = evt[gi] | (stat_r[gi] & ~(wr_stat & avs_writedata[gi]));
        end
    endgenerate

    wire logic [2:0] mask_nxt = wr_mask ? avs_writedata[2:0] : mask_r;
    wire logic irq_nxt = |(stat_nxt & mask_nxt);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl_r <= SPM_CTRL_RESET;
            ctrl_locked_r <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_r <= avs_writedata[15:0] & SPM_CTRL_WMASK;
            ctrl_locked_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ptimer_r <= SPM_PTIMER_RESET;
        end else if (wr_ptimer) begin
            ptimer_r <= avs_writedata[15:0] & SPM_PTIMER_WMASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wd_pre_r <= 9'h000;
            wd_cnt_r <= 16'h0000;
            svc_armed_r <= 1'b0;
            bm_cnt_r <= 7'h00;
        end else begin
            wd_pre_r <= wd_pre_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            svc_armed_r <= svc_arm_nxt;
            bm_cnt_r <= bm_cnt_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pit_pre_r <= 9'h000;
            pit_div_r <= 2'h0;
            pit_cnt_r <= 8'h00;
        end else begin
            pit_pre_r <= pit_pre_nxt;
            pit_div_r <= pit_div_nxt;
            pit_cnt_r <= pit_cnt_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            stat_r <= SPM_EVT_RESET;
            mask_r <= SPM_EVT_RESET;
            irq_r <= 1'b0;
            rst_req_r <= 1'b0;
            bus_err_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
            rst_req_r <= wd_fire | halt_fire;
            bus_err_r <= bm_fire;
        end
    end

    // one wait state on every access keeps read data registered
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= ~(req & wait_r);
            rdata_r <= do_rd_cap ? rd_word : rdata_r;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign system_reset_request = rst_req_r;
    assign bus_error = bus_err_r;
    assign irq = irq_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_bm_stuck;
        bm_watch && bm_cnt_r == bm_lim;
    endsequence

    sequence s_pit_div;
        pit_tick ##1 (pit_div_r == 2'h0);
    endsequence

    chk_ctrl_once: assert property (
        (ctrl_locked_r && do_wr && sel_ctrl) |=> $stable(ctrl_r))
        else $error("control register changed after first write");

    chk_wdog_off: assert property (
        !wd_on |=> wd_cnt_r == 16'h0000 && (!rst_req_r || $past(halt_fire)))
        else $error("disabled watchdog kept counting");

    chk_wdog_pre: assert property (
        (wd_on && ctrl_r.watchdog_prescale_bit && !wd_pre_wrap && !svc_done)
        |=> $stable(wd_cnt_r))
        else $error("prescaled watchdog advanced between ticks");

    chk_wdog_ratio: assert property (
        (wd_tick && !svc_done && wd_cnt_r == wd_lim) |=> wd_cnt_r == 16'h0000)
        else $error("watchdog did not wrap at selected ratio");

    chk_wdog_reset: assert property (
        wd_fire |=> rst_req_r && stat_r[SPM_EVT_WDOG])
        else $error("watchdog timeout gave no reset request");

    chk_halt_mon: assert property (
        (!ctrl_r.halt_monitor_enable && !wd_fire) |=> !rst_req_r)
        else $error("reset request with halt monitor and watchdog quiet");

    chk_bm_off: assert property (
        !ctrl_r.bus_monitor_external_enable |=> bm_cnt_r == 7'h00 && !bus_err_r)
        else $error("disabled bus monitor counted");

    chk_bm_timeout: assert property (
        bus_err_r |-> $past(bm_cnt_r) == $past(bm_lim))
        else $error("bus error at wrong count");

    chk_bm_error: assert property (
        s_bm_stuck |=> bus_err_r ##1 !bus_err_r || $past(bm_fire))
        else $error("stuck bus cycle not ended with bus error");

    chk_pit_stop: assert property (
        !pit_run |=> pit_cnt_r == 8'h00 && !stat_nxt[SPM_EVT_PIT] || stat_r[SPM_EVT_PIT])
        else $error("periodic timer ran with zero modulus");

    chk_pit_div: assert property (
        (pit_run && pit_pre_tick && pit_div_r == SPM_PIT_DIV_MAX) |-> s_pit_div)
        else $error("periodic divider not by four");

    chk_pit_reload: assert property (
        (pit_fire && pit_run) |=> pit_cnt_r == $past(ptimer_r.periodic_timer_modulus))
        else $error("periodic counter not reloaded from modulus");

    chk_svc_zero: assert property (
        (do_rd_cap && sel_svc) |=> avs_readdata == 32'h0000_0000)
        else $error("service register read not zero");

    chk_irq_level: assert property (
        irq_r == |(stat_r & mask_r))
        else $error("irq does not follow masked status");

    chk_ctrl_first: assert property (
        (!ctrl_locked_r && do_wr && sel_ctrl) |=> ctrl_locked_r && ctrl_r.unused == 8'h00)
        else $error("first control write did not lock the register");

    chk_wdog_count: assert property (
        (wd_tick && !svc_done && wd_cnt_r != wd_lim) |=> wd_cnt_r == 16'($past(wd_cnt_r) + 16'h0001))
        else $error("watchdog count did not advance on tick");

    chk_svc_restart: assert property (
        svc_done |=> wd_cnt_r == 16'h0000 && wd_pre_r == 9'h000)
        else $error("service sequence did not restart watchdog");

    chk_halt_reset: assert property (
        halt_fire |=> rst_req_r)
        else $error("enabled halt monitor gave no reset request");

    chk_bm_count: assert property (
        (bm_watch && !bm_fire) |=> bm_cnt_r == 7'($past(bm_cnt_r) + 7'h01))
        else $error("bus monitor did not count open cycle");

    chk_pit_hold: assert property (
        (pit_run && !pit_tick && pit_cnt_r != 8'h00) |=> pit_cnt_r == $past(pit_cnt_r))
        else $error("periodic counter moved between divided ticks");

    chk_pit_irq: assert property (
        pit_fire |=> stat_r[SPM_EVT_PIT])
        else $error("periodic timer expiry did not set status");

    // the answer must come exactly one cycle after the request
    chk_bus_wait: assert property (
        (req && wait_r) |=> !wait_r ##1 wait_r)
        else $error("bus access not answered after one wait state");

endmodule : spm_protect

/* File: verilog/spm_pkg.sv */
package spm_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] SPM_OFS_CTRL = 5'h00;
    localparam logic [4:0] SPM_OFS_PTIMER = 5'h04;
    localparam logic [4:0] SPM_OFS_SVC = 5'h08;
    localparam logic [4:0] SPM_OFS_STAT = 5'h0C;
    localparam logic [4:0] SPM_OFS_MASK = 5'h10;

    // ----------------------------------------------------------------
    // field layouts and reset values
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] unused;
        logic watchdog_enable_bit;
        logic watchdog_prescale_bit;
        logic [1:0] watchdog_timing_field;
        logic halt_monitor_enable;
        logic bus_monitor_external_enable;
        logic [1:0] bus_monitor_timing_field;
    } spm_ctrl_t;

    typedef struct packed {
        logic [6:0] unused;
        logic prescale;
        logic [7:0] periodic_timer_modulus;
    } spm_ptimer_t;

    localparam logic [15:0] SPM_CTRL_RESET = 16'h0080;
    localparam logic [15:0] SPM_PTIMER_RESET = 16'h0000;
    localparam logic [15:0] SPM_CTRL_WMASK = 16'h00FF;
    localparam logic [15:0] SPM_PTIMER_WMASK = 16'h01FF;

    // ----------------------------------------------------------------
    // events: status and mask bit positions
    // ----------------------------------------------------------------
    localparam int SPM_NEVT = 3;
    localparam int SPM_EVT_PIT = 0;
    localparam int SPM_EVT_WDOG = 1;
    localparam int SPM_EVT_BUS = 2;
    localparam logic [2:0] SPM_EVT_RESET = 3'h0;

    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam logic [8:0] SPM_PRE_MAX = 9'h1FF;
    localparam logic [1:0] SPM_PIT_DIV_MAX = 2'h3;
    localparam logic [15:0] SPM_WD_BASE = 16'h0200;
    localparam logic [6:0] SPM_BM_BASE = 7'h40;
    localparam logic [7:0] SPM_SVC_KEY1 = 8'h55;
    localparam logic [7:0] SPM_SVC_KEY2 = 8'hAA;

endpackage : spm_pkg

/* File: tb/spm_far_side.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external bus and halt source seen by the protection block
// ----------------------------------------------------------------
module spm_far_side
    import spm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // commands from the bench
    input wire logic start_cycle,
    input wire logic slow_cycle,
    input wire logic halt_cmd,
    // answer from the block
    input wire logic bus_error,
    // monitored lines
    output logic ext_cycle_active,
    output logic halt_detected
);
    logic [1:0] len_r;

    // a slow cycle never ends by itself: only a bus error terminates it
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ext_cycle_active <= 1'b0;
            len_r <= 2'h0;
        end else if (start_cycle) begin
            ext_cycle_active <= 1'b1;
            len_r <= 2'h0;
        end else if (ext_cycle_active) begin
            len_r <= len_r + 2'h1;
            if (bus_error || (!slow_cycle && len_r == 2'h3)) begin
                ext_cycle_active <= 1'b0;
            end
        end
    end

    assign halt_detected = halt_cmd;
endmodule : spm_far_side

/* File: tb/tb_system_protection_monitors.sv */
`timescale 1ns/1ps
module tb_system_protection_monitors;
    import spm_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, halt_detected, ext_cycle_active;
    logic system_reset_request, bus_error, irq;
    logic start_cycle = 1'b0;
    logic slow_cycle = 1'b0;
    logic halt_cmd = 1'b0;
    logic irq_q = 1'b0;
    logic [2:0] hit;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n_ev[3] = '{0, 0, 0};
    int t_last[3] = '{0, 0, 0};
    int t_prev[3] = '{0, 0, 0};

    always #2 ref_clk = ~ref_clk;

    spm_protect uut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .halt_detected(halt_detected), .ext_cycle_active(ext_cycle_active),
        .system_reset_request(system_reset_request), .bus_error(bus_error), .irq(irq));
    spm_far_side far (.ref_clk(ref_clk), .resetn(resetn), .start_cycle(start_cycle),
        .slow_cycle(slow_cycle), .halt_cmd(halt_cmd), .bus_error(bus_error),
        .ext_cycle_active(ext_cycle_active), .halt_detected(halt_detected));

    // ----------------------------------------------------------------
    // event log: reset requests, irq rises, bus errors
    // ----------------------------------------------------------------
    assign hit = {bus_error === 1'b1, irq === 1'b1 && irq_q !== 1'b1,
        system_reset_request === 1'b1};
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        irq_q <= irq;
        for (int i = 0; i < 3; i++) begin
            if (hit[i]) begin
                n_ev[i] <= n_ev[i] + 1;
                t_prev[i] <= t_last[i];
                t_last[i] <= cyc;
            end
        end
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task hang;
        n_mismatch++;
        print_verdict();
    endtask : hang

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    // one avalon access; read data land in rd
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) hang();
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task wait_ev(input int s, input int b);
        int n0;
        int n;
        n0 = n_ev[s];
        n = 0;
        while (n_ev[s] == n0 && n < b) begin
            @(posedge ref_clk);
            n++;
        end
        if (n_ev[s] == n0) hang();
    endtask : wait_ev

    function automatic logic [31:0] per(input int s);
        return 32'(t_last[s] - t_prev[s]);
    endfunction : per

    task rst;
        resetn <= 1'b0;
        start_cycle <= 1'b0;
        slow_cycle <= 1'b0;
        halt_cmd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
    endtask : rst

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        rst();
        bus(1'b0, SPM_OFS_CTRL, 32'h0000_0000);
        chk("ctrl reset", rd, 32'h0000_0080);
        bus(1'b1, SPM_OFS_SVC, 32'h0000_0055);
        bus(1'b0, SPM_OFS_SVC, 32'h0000_0000);
        chk("svc read", rd, 32'h0000_0000);
        bus(1'b0, 5'h14, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
    endtask : t_regs

    task t_wd(input int sel);
        int p;
        p = 512 << (2 * sel);
        rst();
        bus(1'b1, SPM_OFS_CTRL, 32'(32'h80 | (sel << 4)));
        wait_ev(0, p + 50);
        wait_ev(0, p + 50);
        chk("wd period", per(0), 32'(p));
        bus(1'b0, SPM_OFS_STAT, 32'h0000_0000);
        chk("wd status", rd & 32'h0000_0002, 32'h0000_0002);
    endtask : t_wd

    // prescaled count would be far beyond this wait
    task t_wdpre;
        int n0;
        rst();
        n0 = n_ev[0];
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_00C0);
        repeat (600) @(posedge ref_clk);
        chk("wd prescaled", 32'(n_ev[0] - n0), 32'h0000_0000);
    endtask : t_wdpre

    task t_svc;
        int n0;
        rst();
        n0 = n_ev[0];
        repeat (3) begin
            repeat (300) @(posedge ref_clk);
            bus(1'b1, SPM_OFS_SVC, 32'h0000_0055);
            bus(1'b1, SPM_OFS_SVC, 32'h0000_00AA);
        end
        chk("serviced", 32'(n_ev[0] - n0), 32'h0000_0000);
        wait_ev(0, 600);
    endtask : t_svc

    task t_ctrl;
        int n0;
        rst();
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_000F);
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_00FF);
        bus(1'b0, SPM_OFS_CTRL, 32'h0000_0000);
        chk("ctrl once", rd, 32'h0000_000F);
        n0 = n_ev[0];
        repeat (1200) @(posedge ref_clk);
        chk("wd off", 32'(n_ev[0] - n0), 32'h0000_0000);
        halt_cmd <= 1'b1;
        wait_ev(0, 10);
        halt_cmd <= 1'b0;
        n0 = n_ev[2];
        start_cycle <= 1'b1;
        @(posedge ref_clk);
        start_cycle <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk("short cycle", 32'(n_ev[2] - n0), 32'h0000_0000);
    endtask : t_ctrl

    task t_bmt;
        int k[4];
        int n0;
        int n1;
        for (int b = 3; b >= 0; b--) begin
            rst();
            bus(1'b1, SPM_OFS_CTRL, 32'(32'h04 | b));
            slow_cycle <= 1'b1;
            start_cycle <= 1'b1;
            @(posedge ref_clk);
            start_cycle <= 1'b0;
            k[b] = 0;
            while (bus_error !== 1'b1 && k[b] < 100) begin
                @(posedge ref_clk);
                k[b]++;
            end
            chk("bm fired", 32'(bus_error), 32'h0000_0001);
            chk("bm span", 32'(k[b] - k[3]), 32'((64 >> b) - 8));
            @(posedge ref_clk);
            chk("cycle ended", 32'(ext_cycle_active), 32'h0000_0000);
        end
        rst();
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_0003);
        n0 = n_ev[2];
        n1 = n_ev[0];
        halt_cmd <= 1'b1;
        slow_cycle <= 1'b1;
        start_cycle <= 1'b1;
        @(posedge ref_clk);
        start_cycle <= 1'b0;
        repeat (100) @(posedge ref_clk);
        chk("bm off", 32'(n_ev[2] - n0), 32'h0000_0000);
        chk("halt off", 32'(n_ev[0] - n1), 32'h0000_0000);
    endtask : t_bmt

    // irq rises mark periodic ticks; status is cleared between them
    task t_pit;
        rst();
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_0000);
        bus(1'b1, SPM_OFS_MASK, 32'h0000_0001);
        bus(1'b0, SPM_OFS_MASK, 32'h0000_0000);
        chk("mask", rd, 32'h0000_0001);
        bus(1'b1, SPM_OFS_PTIMER, 32'h0000_0003);
        wait_ev(1, 100);
        bus(1'b1, SPM_OFS_STAT, 32'h0000_0001);
        wait_ev(1, 100);
        chk("pit period", per(1), 32'd12);
        bus(1'b1, SPM_OFS_STAT, 32'h0000_0001);
        bus(1'b1, SPM_OFS_PTIMER, 32'h0000_0005);
        wait_ev(1, 100);
        chk("old count", per(1), 32'd12);
        bus(1'b1, SPM_OFS_STAT, 32'h0000_0001);
        wait_ev(1, 100);
        chk("new modulus", per(1), 32'd20);
        bus(1'b1, SPM_OFS_MASK, 32'h0000_0000);
        bus(1'b1, SPM_OFS_STAT, 32'h0000_0001);
        repeat (50) @(posedge ref_clk);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        bus(1'b0, SPM_OFS_STAT, 32'h0000_0000);
        chk("pit status", rd, 32'h0000_0001);
        bus(1'b1, SPM_OFS_PTIMER, 32'h0000_0000);
        bus(1'b1, SPM_OFS_STAT, 32'h0000_0001);
        repeat (50) @(posedge ref_clk);
        bus(1'b0, SPM_OFS_STAT, 32'h0000_0000);
        chk("pit stopped", rd, 32'h0000_0000);
        bus(1'b1, SPM_OFS_MASK, 32'h0000_0001);
        bus(1'b1, SPM_OFS_PTIMER, 32'h0000_0101);
        wait_ev(1, 2200);
        bus(1'b1, SPM_OFS_STAT, 32'h0000_0001);
        wait_ev(1, 2200);
        chk("pit prescaled", per(1), 32'd2048);
    endtask : t_pit

    initial begin
        t_regs();
        for (int s = 0; s < 4; s++) t_wd(s);
        t_wdpre();
        t_svc();
        t_ctrl();
        t_bmt();
        t_pit();
        print_verdict();
    end
endmodule : tb_system_protection_monitors
